// *** analog_line_record_mapper.sv ***
// Analog line record mapper: record 25 read, record 26 write
`timescale 1ns/1ns
// Function
// RL1: Index 25 read returns whole input image
// RL2: Read reflects current analog input image
// RL3: Index 26 write carries whole output image
// RL4: Write payload stored as output data
// RL5: Eight bytes per address, four channels
// RL6: Area n starts at 2 plus 8(n-1)
// RL7: Input and output share one layout
// RL8: Channel 1 slave 1 at bytes 2,3
// RL9: A slave first two, B last two
// RL10: Bytes 0,1 are version, both zero
module analog_line_record_mapper import line_record_pkg::*; #(
	parameter int fifo_depth = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Record request from the controller
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_index,
	output logic req_ready,
	// Write payload stream, bytes 0..249 in order
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	// Read payload stream, bytes 0..249 in order
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_last,
	input wire logic rd_ready,
	// Completion of a request
	output logic done,
	output logic refused,
	// Analog process images, byte k is record byte k+2
	input wire logic [image_bytes*8-1:0] analog_input_image,
	output logic [image_bytes*8-1:0] analog_output_image,
	output logic analog_output_image_write
);
	if (fifo_depth < 2) begin
		$error("fifo_depth too small");
	end
	mapper_state_t state;
	logic [7:0] pos;
	logic [7:0] f_data;
	logic f_valid;
	logic f_ready;
	logic [7:0] o_data;
	logic o_valid;
	logic o_last;
	logic last_seen;
	logic push_last;
	logic take_out;

	// Record byte position for slave, channel and A/B half
	function automatic logic [7:0] chan_pos(input logic [4:0] slave, input logic [1:0] ch);
		chan_pos = header_bytes + area_bytes * ({3'h0, slave} - 8'h01)
			+ channel_bytes * {6'h00, ch}; // RL5 RL6 RL7 RL8 RL9
	endfunction

	// Record byte at a position: header or slave area, same layout both ways
	function automatic logic [7:0] record_byte(input logic [7:0] p,
			input logic [image_bytes*8-1:0] img);
		logic [7:0] k;
		k = p - header_bytes;
		if (p == 8'h00) record_byte = format_version_high; // RL10
		else if (p == 8'h01) record_byte = format_version_low; // RL10
		else record_byte = img[k*8 +: 8]; // RL2 RL5 RL6 RL7 RL8 RL9
	endfunction

	// ----------------------------------------
	// Request sequencing
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			req_ready <= 1'b0;
			wr_ready <= 1'b0;
			done <= 1'b0;
			refused <= 1'b0;
		end else begin
			done <= 1'b0;
			refused <= 1'b0;
			req_ready <= 1'b0;
			unique case (state)
				st_idle: begin
					if (req_valid && !req_ready) begin
						req_ready <= 1'b1;
						if (!req_write && req_index == index_input_image) begin
							state <= st_read; // RL1
						end else if (req_write && req_index == index_output_image) begin
							state <= st_write; // RL3
							wr_ready <= 1'b1;
						end else begin
							refused <= 1'b1;
						end
					end
				end
				st_read: if (o_valid && o_last && take_out) state <= st_done;
				st_write: begin
					if (wr_valid && wr_ready && pos == record_last) begin
						state <= st_done;
						wr_ready <= 1'b0; // RL3
					end
				end
				st_done: begin
					done <= 1'b1;
					state <= st_idle;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Byte position and write capture
	// ----------------------------------------
	// Output stage can take a new byte when empty or being drained
	assign take_out = !rd_valid || rd_ready;
	assign push_last = f_valid && f_ready && pos == record_last;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos <= '0;
			last_seen <= 1'b0;
		end else if (state == st_idle) begin
			pos <= '0;
			last_seen <= 1'b0;
		end else if ((state == st_write && wr_valid) || (f_valid && f_ready)) begin
			pos <= pos + 8'h01;
			if (push_last) last_seen <= 1'b1;
		end
	end

	// Output image takes payload bytes, header bytes are ignored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_output_image <= '0;
			analog_output_image_write <= 1'b0;
		end else begin
			analog_output_image_write <= 1'b0;
			if (state == st_write && wr_valid && pos >= header_bytes)
				analog_output_image[(pos - header_bytes)*8 +: 8] <= wr_data; // RL4 RL7
			if (state == st_write && wr_valid && pos == record_last)
				analog_output_image_write <= 1'b1; // RL3
		end
	end

	// ----------------------------------------
	// Read path through FIFO
	// ----------------------------------------
	assign f_valid = (state == st_read) && !last_seen;
	assign f_data = record_byte(pos, analog_input_image); // RL1 RL2
	byte_fifo #(.width(9), .depth(fifo_depth)) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_data({pos == record_last, f_data}),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.out_data({o_last, o_data}),
		.out_valid(o_valid),
		.out_ready(take_out)
	);

	// Registered read outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
			rd_last <= 1'b0;
		end else if (take_out) begin
			rd_valid <= o_valid;
			rd_data <= o_data;
			rd_last <= o_valid && o_last;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Completion steps: commit pulse then done, or leaving read then done
	sequence commit_then_done;
		analog_output_image_write ##1 done;
	endsequence
	sequence leave_then_done;
		state == st_done ##1 done;
	endsequence
	chk_version_high_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		(state == st_read && f_valid && pos == 8'h00) |-> f_data == 8'h00)
		else $error("version high byte not zero");
	chk_slave7_offset: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
		chan_pos(5'd7, 2'd0) == 8'd50)
		else $error("slave 7 offset wrong");
	chk_slave30b_offset: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
		chan_pos(5'd30, 2'd2) == 8'd238)
		else $error("slave 30B offset wrong");
	chk_slave1_offset: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
		chan_pos(5'd1, 2'd0) == 8'd2 && chan_pos(5'd31, 2'd3) + 8'd1 == record_last)
		else $error("slave 1 or last offset wrong");
	chk_input_byte_map: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
		(state == st_read && f_valid && pos == 8'd50) |-> f_data == analog_input_image[48*8 +: 8])
		else $error("input byte mapped wrongly");
	chk_read_accept: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
		(state == st_idle && req_valid && !req_ready && !req_write && req_index == index_input_image)
		|=> state == st_read)
		else $error("index 25 read not started");
	chk_write_store: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		(state == st_write && wr_valid && pos == 8'd242)
		|=> analog_output_image[240*8 +: 8] == $past(wr_data))
		else $error("output byte not stored");
	chk_write_commit: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		(state == st_write && wr_valid && pos == record_last)
		|=> commit_then_done)
		else $error("write not committed");
	chk_area_size: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
		chan_pos(5'd2, 2'd0) - chan_pos(5'd1, 2'd0) == area_bytes)
		else $error("area size wrong");
	chk_refuse_index: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		(state == st_idle && req_valid && !req_ready && req_write && req_index != index_output_image)
		|=> refused && state == st_idle)
		else $error("bad index not refused");
	chk_read_finish: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
		(state == st_read && o_valid && o_last && take_out)
		|=> leave_then_done)
		else $error("read not finished after last byte");
	chk_read_tail: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
		(state == st_read && f_valid && pos == record_last)
		|-> f_data == analog_input_image[image_bytes*8-8 +: 8])
		else $error("last record byte mapped wrongly");
	chk_write_ready: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		wr_ready == (state == st_write))
		else $error("write ready out of step with state");
endmodule

// *** line_record_pkg.sv ***
// Constants for the analog line record mapper
package line_record_pkg;
	localparam logic [7:0] index_input_image = 8'h19; // Record index 25
	localparam logic [7:0] index_output_image = 8'h1a; // Record index 26
	localparam logic [7:0] format_version_high = 8'h00;
	localparam logic [7:0] format_version_low = 8'h00;
	localparam logic [7:0] header_bytes = 8'h02; // First slave area starts here
	localparam logic [7:0] area_bytes = 8'h08; // Bytes per slave address
	localparam logic [7:0] channel_bytes = 8'h02; // Bytes per channel
	localparam logic [7:0] b_slave_offset = 8'h04; // B slave starts 4 bytes in
	localparam logic [7:0] slave_count = 8'h1f; // Addresses 1 to 31
	localparam logic [7:0] record_last = 8'hf9; // Byte 249
	localparam logic [7:0] image_bytes = 8'hf8; // 31 areas of 8 bytes
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_read = 2'b01,
		st_write = 2'b10,
		st_done = 2'b11
	} mapper_state_t;
endpackage

// *** byte_fifo.sv ***
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ns
module byte_fifo #(
	parameter int width = 8,
	parameter int depth = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic [width-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [width-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int aw = $clog2(depth);
	if (depth < 2 || (1 << aw) != depth) begin
		$error("depth must be a power of two");
	end
	logic [width-1:0] mem [depth];
	logic [aw:0] wr_ptr;
	logic [aw:0] rd_ptr;
	logic push;
	logic pop;
	// Full and empty from pointer comparison
	assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {aw{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[aw-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage
	always_ff @(posedge core_clk) begin
		if (push) mem[wr_ptr[aw-1:0]] <= in_data;
	end
	// Pointers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
		end
	end
	chk_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (!rst_n)
		!in_ready |-> (wr_ptr[aw-1:0] == rd_ptr[aw-1:0]))
		else $error("fifo full flag wrong");
endmodule

// *** record_controller.sv ***
// Controller model: issues record requests and streams the write payload
`timescale 1ns/1ns
module record_controller (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Commands from the bench
	input wire logic start,
	input wire logic write,
	input wire logic [7:0] index,
	input wire logic [7:0] seed,
	input wire logic stall,
	// Mapper side
	output logic req_valid,
	output logic req_write,
	output logic [7:0] req_index,
	input wire logic req_ready,
	output logic [7:0] wr_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic rd_ready
);
	int count = 250;
	logic took, got, go, w;
	logic [7:0] idx;
	// Idle values at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_index = 8'h00;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		rd_ready = 1'b0;
	end
	// Request held until taken, then bytes 0..249 in record order
	always @(posedge core_clk) begin
		took = wr_valid && wr_ready;
		got = req_valid && req_ready;
		go = start;
		w = write;
		idx = index;
		#1;
		if (got) req_valid = 1'b0;
		if (took) count++;
		if (go) begin
			req_valid = 1'b1;
			req_write = w;
			req_index = idx;
			count = 0;
		end
		wr_valid = rst_n && req_write && !req_valid && count < 250;
		// Version bytes zero, payload bytes marked by position
		wr_data = !wr_valid ? ~wr_data : (count < 2 ? 8'h00 : 8'(count) ^ seed);
		rd_ready = rst_n && !stall;
	end
endmodule

// *** tb_analog_line_record_mapper.sv ***
// Bench for the analog line record mapper
`timescale 1ns/1ns
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: %h wanted %h", $time, a, b); end end
module tb_analog_line_record_mapper import line_record_pkg::*; ;
	logic core_clk = 1'b0, rst_n = 1'b0, start = 1'b0, write = 1'b0, stall = 1'b0;
	logic [7:0] index = 8'h00, seed = 8'h00, req_index, wr_data, rd_data;
	logic req_valid, req_write, req_ready, wr_valid, wr_ready, rd_valid, rd_last, rd_ready;
	logic done, refused, analog_output_image_write;
	logic [image_bytes*8-1:0] analog_input_image = '0, analog_output_image;
	logic [8:0] notes[$];
	logic [8:0] want;
	logic [31:0] rng = 32'h698de1ea;
	int fails = 0, comparisons = 0, cycles = 0;
	analog_line_record_mapper uut (.core_clk, .rst_n, .req_valid, .req_write, .req_index,
		.req_ready, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_last, .rd_ready,
		.done, .refused, .analog_input_image, .analog_output_image, .analog_output_image_write);
	record_controller ctrl (.core_clk, .rst_n, .start, .write, .index, .seed, .stall,
		.req_valid, .req_write, .req_index, .req_ready, .wr_data, .wr_valid, .wr_ready,
		.rd_ready);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Clock and cycle ceiling
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end
	// Output watcher: each read byte taken is matched to the oldest note
	always @(posedge core_clk) begin
		if (rst_n && rd_valid && rd_ready) begin
			if (notes.size() == 0) `check(1'b1, 1'b0)
			else begin
				want = notes.pop_front();
				`check({rd_last, rd_data}, want)
			end
		end
	end
	// One request, waited for under a bound, with random read stalls
	task automatic request(input logic w, input logic [7:0] idx, input logic refuse);
		logic seen;
		int takes;
		int commits;
		@(posedge core_clk);
		#1 write = w;
		index = idx;
		start = 1'b1;
		@(posedge core_clk);
		#1 start = 1'b0;
		seen = 1'b0;
		takes = 0;
		commits = 0;
		for (int n = 0; n < 3000 && !seen; n++) begin
			@(negedge core_clk);
			seen = done || refused;
			if (req_ready) takes++;
			rng = xs(rng);
			stall = rng[1] & rng[0];
			if (analog_output_image_write) begin
				commits++;
				for (int k = 0; k < 248; k++)
					`check(analog_output_image[8*k+:8], 8'(k + 2) ^ seed)
				`check(analog_output_image[8*236+:8], 8'd238 ^ seed)
			end
		end
		`check(seen, 1'b1)
		`check(refused, refuse)
		`check(takes, 1)
		`check(commits, int'(w && !refuse))
		stall = 1'b0;
		repeat (4) @(negedge core_clk);
		`check(notes.size(), 0)
	endtask
	// Main sequence: two reads on fresh images, a write, refused directions and an unknown index
	initial begin
		repeat (16) @(posedge core_clk);
		#1 rst_n = 1'b1;
		for (int r = 0; r < 2; r++) begin
			@(posedge core_clk);
			#1;
			for (int k = 0; k < 62; k++) begin
				rng = xs(rng);
				analog_input_image[32*k+:32] = rng;
			end
			for (int k = 0; k < 250; k++)
				notes.push_back({k == 249, k < 2 ? 8'h00 : analog_input_image[8*k-16+:8]});
			request(1'b0, index_input_image, 1'b0);
		end
		seed = rng[15:8];
		request(1'b1, index_output_image, 1'b0);
		request(1'b1, index_input_image, 1'b1);
		request(1'b0, index_output_image, 1'b1);
		request(1'b0, 8'h00, 1'b1);
		complete_run();
	end
endmodule
